// file: egs_bank.sv
// Echo DSP gain, scaling, trim and decouple configuration register bank
`timescale 1ns/10ps
module egs_bank
  import egs_pkg::*;
(
  input wire logic clk,               // 200 MHz system clock
  input wire logic reset,             // Asynchronous reset, active high
  input wire egs_bus_t bus,           // Register port request
  output logic [7:0] rdata,           // Read data, cycle after read strobe
  output egs_cfg_t cfg,               // Decoded global settings
  output egs_preset_t preset1,        // Decoded first preset plan
  output egs_preset_t preset2         // Decoded second preset plan
);

  typedef struct packed {
    logic [7:0] decouple;
    logic [7:0] scale;
    logic [7:0] trim;
    logic [7:0] gain1;
    logic [7:0] gain2;
    logic [1:0] nl_en;
    logic [7:0] rdata;
    egs_cfg_t cfg;
    egs_preset_t p1;
    egs_preset_t p2;
  } egs_state_t;

  egs_state_t state_q;
  egs_state_t state_d;

  // ==========================================================================
  // Decode helpers
  function automatic logic [5:0] egs_mult(input logic [2:0] code);
    logic [5:0] m;
    m = 6'h00;
    if (code <= EGS_GAIN_MAX_CODE) begin
      m = 6'(6'h01 << code);
    end
    return m;
  endfunction

  function automatic egs_preset_t egs_preset(input logic [7:0] r, input logic en);
    egs_preset_t p;
    p.nl_en = en;
    p.far_start_point = EGS_TH_BASE + 4'(r[EGS_FSTART_LSB +: 2]);
    p.far_mult = egs_mult(r[EGS_FAR_LSB +: 3]);
    p.near_mult = egs_mult(r[EGS_NEAR_LSB +: 3]);
    p.far_invalid = r[EGS_FAR_LSB +: 3] > EGS_GAIN_MAX_CODE;
    p.near_invalid = r[EGS_NEAR_LSB +: 3] > EGS_GAIN_MAX_CODE;
    return p;
  endfunction

  function automatic logic [10:0] egs_noise(input logic [4:0] lvl, input logic [5:0] g);
    logic [10:0] n;
    n = {6'h00, lvl};
    if (g > EGS_NOISE_DIV_GAIN) begin
      // Widen both factors first so the product is not cut to six bits
      n = ({6'h00, lvl} * {5'h00, g}) >> EGS_NOISE_DIV_SHIFT;
    end
    return n;
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic [3:0] dv;
    logic [5:0] far_max;
    dv = 4'h0;
    far_max = 6'h00;
    state_d = state_q;
    state_d.rdata = 8'h00;
    if (bus.wr) begin
      if (bus.addr == EGS_OFF_DECOUPLE) begin
        state_d.decouple = bus.wdata;
      end else if (bus.addr == EGS_OFF_SCALE) begin
        state_d.scale = bus.wdata;
      end else if (bus.addr == EGS_OFF_TRIM) begin
        state_d.trim = bus.wdata;
      end else if (bus.addr == EGS_OFF_GAIN1) begin
        state_d.gain1 = bus.wdata;
      end else if (bus.addr == EGS_OFF_GAIN2) begin
        state_d.gain2 = bus.wdata;
      end else if (bus.addr == EGS_OFF_NLEN) begin
        state_d.nl_en = {bus.wdata[EGS_NL2_BIT], bus.wdata[EGS_NL1_BIT]};
      end
    end
    if (bus.rd) begin
      if (bus.addr == EGS_OFF_DECOUPLE) begin
        state_d.rdata = state_q.decouple;
      end else if (bus.addr == EGS_OFF_SCALE) begin
        state_d.rdata = state_q.scale;
      end else if (bus.addr == EGS_OFF_TRIM) begin
        state_d.rdata = state_q.trim;
      end else if (bus.addr == EGS_OFF_GAIN1) begin
        state_d.rdata = state_q.gain1;
      end else if (bus.addr == EGS_OFF_GAIN2) begin
        state_d.rdata = state_q.gain2;
      end else if (bus.addr == EGS_OFF_NLEN) begin
        state_d.rdata = {state_q.nl_en[1], 6'h00, state_q.nl_en[0]};
      end
    end
    // Outputs follow the registers one cycle after a write; noise_eff follows a gain write one cycle later still
    state_d.cfg.span_lo_db = EGS_SPAN_LO_DB[state_q.decouple[EGS_SPAN_LSB +: 2]];
    state_d.cfg.span_hi_db = EGS_SPAN_HI_DB[state_q.decouple[EGS_SPAN_LSB +: 2]];
    state_d.cfg.sleep_allow = state_q.decouple[EGS_SLEEP_BIT];
    state_d.cfg.decouple_kind_select = state_q.decouple[EGS_KIND_BIT];
    dv = state_q.decouple[EGS_DVAL_LSB +: 4];
    state_d.cfg.decouple_time_us = 17'(EGS_DECOUPLE_STEP_US * (dv + 1));
    state_d.cfg.decouple_temp_c = 9'(EGS_DEG_STEP * dv - EGS_DEG_BASE);
    // Noise follows the larger far gain of the two presets, enabled or not
    far_max = (state_q.p1.far_mult > state_q.p2.far_mult) ?
      state_q.p1.far_mult : state_q.p2.far_mult;
    state_d.cfg.noise_eff = egs_noise(state_q.scale[EGS_NOISE_LSB +: 5], far_max);
    state_d.cfg.exponent_two = state_q.scale[EGS_EXP_BIT];
    state_d.cfg.nl_start_point = EGS_TH_BASE + 4'(state_q.scale[EGS_NSTART_LSB +: 2]);
    state_d.cfg.temp_gain = signed'(state_q.trim[EGS_TGAIN_LSB +: 4]);
    state_d.cfg.temp_off = signed'(state_q.trim[EGS_TOFF_LSB +: 4]);
    state_d.p1 = egs_preset(state_q.gain1, state_q.nl_en[0]);
    state_d.p2 = egs_preset(state_q.gain2, state_q.nl_en[1]);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
      state_q.decouple <= EGS_RST_DECOUPLE;
      state_q.scale <= EGS_RST_SCALE;
      state_q.trim <= EGS_RST_TRIM;
      state_q.gain1 <= EGS_RST_GAIN;
      state_q.gain2 <= EGS_RST_GAIN;
      state_q.nl_en <= EGS_RST_NLEN;
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata = state_q.rdata;
  assign cfg = state_q.cfg;
  assign preset1 = state_q.p1;
  assign preset2 = state_q.p2;

endmodule

// file: egs_bank_sva.sv
// Checker for the gain and scaling configuration bank
`timescale 1ns/10ps
module egs_bank_chk
  import egs_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire egs_bus_t bus, // Request
  input wire logic [7:0] rdata, // Read data
  input wire egs_cfg_t cfg, // Settings
  input wire egs_preset_t preset1, // Preset one
  input wire egs_preset_t preset2 // Preset two
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // Write seen two edges back
  egs_bus_t b1_q, b2_q;
  logic [7:0] ha, d;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      b1_q <= '0;
      b2_q <= '0;
    end else begin
      b1_q <= bus;
      b2_q <= b1_q;
    end
  end
  assign ha = b2_q.wr ? b2_q.addr : 8'h00;
  assign d = b2_q.wdata;
  // ==========================================================================
  // Decode relations
  a_span_sleep:
    assert property (ha == EGS_OFF_DECOUPLE |-> cfg.span_lo_db == EGS_SPAN_LO_DB[d[7:6]]
      && cfg.span_hi_db == EGS_SPAN_HI_DB[d[7:6]] && cfg.sleep_allow == d[5])
    else $error("span or sleep decode wrong");
  a_decouple_math:
    assert property (ha == EGS_OFF_DECOUPLE |-> cfg.decouple_kind_select == d[4]
      && cfg.decouple_time_us == 17'(4096 * (d[3:0] + 1))
      && int'(cfg.decouple_temp_c) == 10 * d[3:0] - 40)
    else $error("decouple decode wrong");
  a_scale_point:
    assert property (ha == EGS_OFF_SCALE |-> cfg.exponent_two == d[2]
      && cfg.nl_start_point == 4'd9 + d[1:0]) else $error("scale decode wrong");
  a_trim_fields:
    assert property (ha == EGS_OFF_TRIM |-> cfg.temp_gain == d[7:4]
      && cfg.temp_off == d[3:0]) else $error("trim decode wrong");
  a_gain_one:
    assert property (ha == EGS_OFF_GAIN1 && d[5:3] < 3'd6 && d[2:0] < 3'd6 |->
      preset1.far_start_point == 4'd9 + d[7:6] && preset1.far_mult == 6'd1 << d[5:3]
      && preset1.near_mult == 6'd1 << d[2:0]) else $error("preset one decode wrong");
  a_gain_two:
    assert property (ha == EGS_OFF_GAIN2 && d[5:3] < 3'd6 && d[2:0] < 3'd6 |->
      preset2.far_start_point == 4'd9 + d[7:6] && preset2.far_mult == 6'd1 << d[5:3]
      && preset2.near_mult == 6'd1 << d[2:0]) else $error("preset two decode wrong");
  a_nl_enables:
    assert property (ha == EGS_OFF_NLEN |-> preset1.nl_en == d[0]
      && preset2.nl_en == d[7]) else $error("non-linear enable wrong");
  a_read_unmapped:
    assert property (bus.rd && !(bus.addr inside {[EGS_OFF_DECOUPLE:EGS_OFF_NLEN]})
      |=> rdata == 8'h00) else $error("unmapped read not zero");
  c_gain_one: cover property (ha == EGS_OFF_GAIN1);
  c_temp_kind: cover property (ha == EGS_OFF_DECOUPLE && d[4]);
  c_read_pair: cover property (bus.rd ##1 bus.rd);
endmodule

bind egs_bank egs_bank_chk u_chk (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
  .cfg(cfg), .preset1(preset1), .preset2(preset2));

// file: egs_pkg.sv
// Package for the echo DSP gain and scaling configuration bank
package egs_pkg;

  // ==========================================================================
  // Register offsets (byte index on the plain register port)
  localparam logic [7:0] EGS_OFF_DECOUPLE = 8'h26;
  localparam logic [7:0] EGS_OFF_SCALE = 8'h27;
  localparam logic [7:0] EGS_OFF_TRIM = 8'h28;
  localparam logic [7:0] EGS_OFF_GAIN1 = 8'h29;
  localparam logic [7:0] EGS_OFF_GAIN2 = 8'h2a;
  localparam logic [7:0] EGS_OFF_NLEN = 8'h2b;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] EGS_RST_DECOUPLE = 8'h00;
  localparam logic [7:0] EGS_RST_SCALE = 8'h00;
  localparam logic [7:0] EGS_RST_TRIM = 8'h00;
  localparam logic [7:0] EGS_RST_GAIN = 8'h00;
  localparam logic [1:0] EGS_RST_NLEN = 2'h0;

  // ==========================================================================
  // Field positions
  localparam int EGS_SPAN_LSB = 6;
  localparam int EGS_SLEEP_BIT = 5;
  localparam int EGS_KIND_BIT = 4;
  localparam int EGS_DVAL_LSB = 0;
  localparam int EGS_NOISE_LSB = 3;
  localparam int EGS_EXP_BIT = 2;
  localparam int EGS_NSTART_LSB = 0;
  localparam int EGS_TGAIN_LSB = 4;
  localparam int EGS_TOFF_LSB = 0;
  localparam int EGS_FSTART_LSB = 6;
  localparam int EGS_FAR_LSB = 3;
  localparam int EGS_NEAR_LSB = 0;
  localparam int EGS_NL1_BIT = 0;
  localparam int EGS_NL2_BIT = 7;

  // ==========================================================================
  // Decoded values
  localparam logic [6:0] EGS_SPAN_LO_DB [4] = '{7'd58, 7'd52, 7'd46, 7'd32};
  localparam logic [6:0] EGS_SPAN_HI_DB [4] = '{7'd90, 7'd84, 7'd78, 7'd64};
  localparam int EGS_DECOUPLE_STEP_US = 4096;
  localparam int EGS_DEG_STEP = 10;
  localparam int EGS_DEG_BASE = 40;
  localparam logic [3:0] EGS_TH_BASE = 4'd9;
  localparam logic [2:0] EGS_GAIN_MAX_CODE = 3'h5;
  localparam logic [5:0] EGS_NOISE_DIV_GAIN = 6'd8;
  localparam int EGS_NOISE_DIV_SHIFT = 3;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } egs_bus_t;

  // Per-preset decoded gain plan
  typedef struct packed {
    logic nl_en;
    logic [3:0] far_start_point;
    logic [5:0] far_mult;
    logic [5:0] near_mult;
    logic far_invalid;
    logic near_invalid;
  } egs_preset_t;

  // Global decoded settings
  typedef struct packed {
    logic [6:0] span_lo_db;
    logic [6:0] span_hi_db;
    logic sleep_allow;
    logic decouple_kind_select;
    logic [16:0] decouple_time_us;
    logic signed [8:0] decouple_temp_c;
    logic exponent_two;
    logic [3:0] nl_start_point;
    logic [10:0] noise_eff;
    logic signed [3:0] temp_gain;
    logic signed [3:0] temp_off;
  } egs_cfg_t;

endpackage

// file: testbench.sv
// Self-checking testbench for the gain and scaling configuration bank
`timescale 1ns/10ps
module testbench
  import egs_pkg::*;
;
  logic clk = 0, reset = 1, rd_pend = 0;
  egs_bus_t bus = '0;
  logic [7:0] rdata, rd_exp;
  egs_cfg_t cfg;
  egs_preset_t preset1, preset2;
  int err_count = 0, checks = 0;
  int lo[4] = '{58, 52, 46, 32};
  int hi[4] = '{90, 84, 78, 64};
  egs_bank uut (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .cfg(cfg),
    .preset1(preset1), .preset2(preset2));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic conclude;
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    rd_exp = e;
    rd_pend = 1;
  endtask
  // Let a write reach the decoded outputs, then look mid-cycle
  task automatic idle2;
    repeat (2) begin
      bus <= '0;
      @(posedge clk);
    end
    @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (rd_pend) begin
      cmp("rdata", rd_exp, rdata);
      rd_pend = 0;
    end
  end
  initial begin
    #20000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    for (int a = 38; a < 44; a++) rd(8'(a), 8'h00);
    idle2;
    cmp("time", 4096, cfg.decouple_time_us);
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      wr(EGS_OFF_DECOUPLE, {2'(k), k[0], k[1], 4'(k * 5)});
      idle2;
      cmp("span_lo", lo[k], cfg.span_lo_db);
      cmp("span_hi", hi[k], cfg.span_hi_db);
      cmp("sleep", k[0], cfg.sleep_allow);
      cmp("kind", k[1], cfg.decouple_kind_select);
      cmp("time", 4096 * (k * 5 + 1), cfg.decouple_time_us);
      cmp("temp", 50 * k - 40, cfg.decouple_temp_c);
      @(posedge clk);
      wr(EGS_OFF_SCALE, {5'd31, k[0], 2'(k)});
      idle2;
      cmp("exp", k[0], cfg.exponent_two);
      cmp("start", 9 + k, cfg.nl_start_point);
      @(posedge clk);
    end
    wr(EGS_OFF_TRIM, 8'h87);
    idle2;
    cmp("tgain", -8, cfg.temp_gain);
    cmp("toff", 7, cfg.temp_off);
    @(posedge clk);
    for (int g = 0; g < 6; g++) begin
      wr(EGS_OFF_GAIN1, {2'(g), 3'(g), 3'(5 - g)});
      wr(EGS_OFF_GAIN2, {2'(g + 1), 3'(g), 3'(g)});
      idle2;
      cmp("start1", 9 + g % 4, preset1.far_start_point);
      cmp("far1", 1 << g, preset1.far_mult);
      cmp("near1", 1 << (5 - g), preset1.near_mult);
      cmp("start2", 9 + (g + 1) % 4, preset2.far_start_point);
      cmp("far2", 1 << g, preset2.far_mult);
      cmp("near2", 1 << g, preset2.near_mult);
      cmp("ok1", 0, {preset1.far_invalid, preset1.near_invalid});
      cmp("ok2", 0, {preset2.far_invalid, preset2.near_invalid});
      cmp("noise", g > 3 ? 31 * (1 << g) / 8 : 31, cfg.noise_eff);
      @(posedge clk);
    end
    wr(EGS_OFF_GAIN1, 8'h36);
    wr(EGS_OFF_GAIN2, 8'h3f);
    rd(EGS_OFF_GAIN1, 8'h36);
    idle2;
    cmp("bad1", 1, preset1.near_invalid);
    cmp("bad2", 1, preset2.far_invalid);
    cmp("bad1f", 1, preset1.far_invalid);
    cmp("bad2n", 1, preset2.near_invalid);
    cmp("near2", 0, preset2.near_mult);
    @(posedge clk);
    for (int n = 0; n < 2; n++) begin
      wr(EGS_OFF_NLEN, {n[0], 6'h00, 1'b1});
      idle2;
      cmp("nl1", 1, preset1.nl_en);
      cmp("nl2", n[0], preset2.nl_en);
      @(posedge clk);
    end
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00);
    rd(EGS_OFF_TRIM, 8'h87);
    rd(8'h25, 8'h00);
    rd(EGS_OFF_SCALE, 8'hff);
    rd(EGS_OFF_NLEN, 8'h81);
    rd(EGS_OFF_DECOUPLE, 8'hff);
    rd(EGS_OFF_GAIN2, 8'h3f);
    idle2;
    // Reset in mid-run must bring the trim, gain1 and decouple registers back to their reset values
    @(posedge clk);
    reset <= 1;
    @(posedge clk);
    reset <= 0;
    rd(EGS_OFF_TRIM, EGS_RST_TRIM);
    rd(EGS_OFF_GAIN1, EGS_RST_GAIN);
    idle2;
    cmp("time", 4096, cfg.decouple_time_us);
    cmp("start1", 9, preset1.far_start_point);
    conclude();
  end
endmodule
